// ==== rtl/sft_core.sv ====
// serial flash target: link shifter, command decoder, internal cycles and array
`timescale 1ns/1ps
`default_nettype none
module sft_core #(
    parameter int unsigned PROG_CYCLES = sft_pkg::PROG_CYCLES,
    parameter int unsigned SECTOR_CYCLES = sft_pkg::SECTOR_CYCLES,
    parameter int unsigned BULK_CYCLES = sft_pkg::BULK_CYCLES,
    parameter int unsigned STATUS_CYCLES = sft_pkg::STATUS_CYCLES,
    // identity byte, value is arbitrary
    parameter logic [7:0] DEVICE_ID = sft_pkg::ID_DEFAULT
) (
    // system clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // serial link from the host
    input wire logic link_sclk_in,
    input wire logic cs_n_in,
    input wire logic hold_n_in,
    input wire logic wp_n_in,
    input wire logic serial_in,
    // serial output, three-state
    output logic serial_out,
    output logic serial_oe_out
);
    import sft_pkg::*;

    // saturating byte counter step
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction : sat_inc

    // ---------------- link clock domain ----------------

    // frame logic reset: power reset or deselect
    logic link_rst_n;
    // output driver reset: also pause
    logic drive_rst_n;
    assign link_rst_n = rstn_in & ~cs_n_in;
    assign drive_rst_n = link_rst_n & hold_n_in;

    // status, sleep and armed levels into link domain
    logic [7:0] stat_s1_q;
    logic [7:0] stat_s2_q;
    logic deep_s1_q;
    logic deep_s2_q;
    logic armed_s1_q;
    logic armed_s2_q;

    // frame counters, cleared by deselect
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [15:0] byte_cnt_q;
    // outgoing byte and read flag
    logic [7:0] tx_q;
    logic reading_q;

    // frame record, kept after deselect for the system side
    logic [7:0] rec_op_q;
    logic [23:0] rec_addr_q;
    logic [15:0] rec_bytes_q;
    logic rec_partial_q;
    logic rec_armed_q;

    // page buffer filled by program data
    logic [7:0] page_buf_q [256];
    logic [255:0] page_mask_q;

    // byte assembled on this edge
    logic [7:0] rx_byte;
    // eighth bit of a byte arrives
    logic byte_done;
    // first edge of a frame
    logic frame_first;
    // link may touch record
    logic link_live;
    // page buffer slot of this data byte
    logic [7:0] buf_idx;
    // buffer frozen while a cycle runs
    logic buf_open;

    assign rx_byte = {shift_q, serial_in};
    assign byte_done = hold_n_in && (bit_cnt_q == 3'h7);
    assign frame_first = (byte_cnt_q == 16'h0000) && (bit_cnt_q == 3'h0);
    assign link_live = !cs_n_in && hold_n_in;
    assign buf_idx = rec_addr_q[7:0] + 8'(byte_cnt_q - HDR_BYTES);
    assign buf_open = !stat_s2_q[ST_BUSY_BIT];

    // two-stage synchronisers on the link clock
    always_ff @(posedge link_sclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stat_s1_q <= 8'h00;
            stat_s2_q <= 8'h00;
            deep_s1_q <= 1'b0;
            deep_s2_q <= 1'b0;
            armed_s1_q <= 1'b0;
            armed_s2_q <= 1'b0;
        end else begin
            stat_s1_q <= stat_q;
            stat_s2_q <= stat_s1_q;
            deep_s1_q <= deep_q;
            deep_s2_q <= deep_s1_q;
            armed_s1_q <= armed_q;
            armed_s2_q <= armed_s1_q;
        end
    end

    // same edge in mode 0 and 3
    always_ff @(posedge link_sclk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 7'h00;
            byte_cnt_q <= 16'h0000;
        end else if (hold_n_in) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q <= rx_byte[6:0];
            if (bit_cnt_q == 3'h7) begin
                byte_cnt_q <= sat_inc(byte_cnt_q);
            end
        end
    end

    // read path: status repeats, id after header
    always_ff @(posedge link_sclk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            reading_q <= 1'b0;
            tx_q <= 8'h00;
        end else if (byte_done) begin
            if (byte_cnt_q == 16'h0000) begin
                reading_q <= armed_s2_q && !deep_s2_q && (rx_byte == OP_STATUS_READ);
                tx_q <= stat_s2_q;
            end else if (rec_op_q == OP_STATUS_READ) begin
                // live status on every byte
                tx_q <= stat_s2_q;
            end else if (rec_op_q == OP_WAKE_ID && byte_cnt_q >= WAKE_HDR_BYTES - 16'h0001) begin
                reading_q <= rec_armed_q;
                tx_q <= DEVICE_ID;
            end else begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end else if (hold_n_in) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    always_ff @(negedge link_sclk_in or negedge drive_rst_n) begin
        if (!drive_rst_n) begin
            serial_out <= 1'b0;
            serial_oe_out <= 1'b0;
        end else begin
            serial_out <= tx_q[7];
            serial_oe_out <= reading_q;
        end
    end

    // frame record survives deselect so the system side can act on it
    always_ff @(posedge link_sclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rec_op_q <= 8'h00;
            rec_addr_q <= 24'h00_0000;
            rec_bytes_q <= 16'h0000;
            rec_partial_q <= 1'b0;
            rec_armed_q <= 1'b0;
        end else if (link_live) begin
            rec_partial_q <= (bit_cnt_q != 3'h7);
            if (frame_first) begin
                rec_bytes_q <= 16'h0000;
            end
            if (byte_done) begin
                rec_bytes_q <= sat_inc(byte_cnt_q);
                if (byte_cnt_q == 16'h0000) begin
                    rec_op_q <= rx_byte;
                    rec_armed_q <= armed_s2_q;
                end else if (byte_cnt_q < HDR_BYTES) begin
                    rec_addr_q <= {rec_addr_q[15:0], rx_byte};
                end
            end
        end
    end

    // page mask: cleared at frame start, frozen during cycles
    always_ff @(posedge link_sclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            page_mask_q <= '0;
        end else if (link_live && buf_open) begin
            if (frame_first) begin
                page_mask_q <= '0;
            end else if (byte_done && rec_op_q == OP_PAGE_PROGRAM && byte_cnt_q >= HDR_BYTES) begin
                page_mask_q[buf_idx] <= 1'b1;
            end
        end
    end

    // page data store, no reset needed behind the mask
    always_ff @(posedge link_sclk_in) begin
        if (link_live && buf_open && byte_done && rec_op_q == OP_PAGE_PROGRAM
            && byte_cnt_q >= HDR_BYTES) begin
            page_buf_q[buf_idx] <= rx_byte;
        end
    end

    // ---------------- system clock domain ----------------

    // select and protect pin synchronisers
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic wp_s1_q;
    logic wp_s2_q;
    // select has been seen high since reset
    logic armed_q;
    // sleep mode
    logic deep_q;
    // write latch, guard and lock bits
    logic latch_q;
    logic [2:0] guard_q;
    logic lock_q;
    // status image for the link side
    logic [7:0] stat_q;
    // internal cycle machine
    sft_state_type state_q;
    logic [31:0] timer_q;
    logic [18:0] walk_q;
    logic [19:0] left_q;
    // array contents
    logic [7:0] mem_q [ARRAY_WORDS];

    // end of a frame, seen one sync later
    logic frame_end;
    // frame well-formed and machine free
    logic cmd_ok;
    logic busy;
    logic cycle_done;
    logic start_prog;
    logic start_sector;
    logic start_bulk;
    logic start_stat;

    assign frame_end = cs_s2_q && !cs_s3_q;
    assign busy = (state_q != ST_IDLE);
    // cycles end on their own, not on select
    assign cycle_done = busy && (timer_q == 32'h0000_0000) && (left_q == 20'h0_0000);
    assign cmd_ok = frame_end && rec_armed_q && !rec_partial_q && !deep_q && !busy;
    assign start_prog = cmd_ok && latch_q && rec_op_q == OP_PAGE_PROGRAM
        && rec_bytes_q > HDR_BYTES && !sft_guarded(rec_addr_q[18:0], guard_q);
    assign start_sector = cmd_ok && latch_q && rec_op_q == OP_SECTOR_ERASE
        && rec_bytes_q == HDR_BYTES && !sft_guarded(rec_addr_q[18:0], guard_q);
    assign start_bulk = cmd_ok && latch_q && rec_op_q == OP_BULK_ERASE
        && rec_bytes_q == ONE_BYTE && guard_q == 3'h0;
    assign start_stat = cmd_ok && latch_q && rec_op_q == OP_STATUS_WRITE
        && rec_bytes_q == STATUS_WR_BYTES && !(lock_q && !wp_s2_q);

    // pin synchronisers; third select stage only for edge detect
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cs_s1_q <= 1'b0;
            cs_s2_q <= 1'b0;
            cs_s3_q <= 1'b0;
            wp_s1_q <= 1'b0;
            wp_s2_q <= 1'b0;
        end else begin
            cs_s1_q <= cs_n_in;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= wp_n_in;
            wp_s2_q <= wp_s1_q;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            armed_q <= 1'b0;
        end else if (cs_s2_q) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            deep_q <= 1'b0;
        end else if (frame_end && rec_armed_q && deep_q && rec_op_q == OP_WAKE_ID
            && rec_bytes_q >= ONE_BYTE) begin
            deep_q <= 1'b0;
        end else if (cmd_ok && rec_op_q == OP_DEEP_SLEEP && rec_bytes_q == ONE_BYTE) begin
            deep_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            latch_q <= 1'b0;
        end else if (cmd_ok && rec_op_q == OP_WRITE_ENABLE && rec_bytes_q == ONE_BYTE) begin
            latch_q <= 1'b1;
        end else if (cmd_ok && rec_op_q == OP_WRITE_DISABLE && rec_bytes_q == ONE_BYTE) begin
            latch_q <= 1'b0;
        end else if (cycle_done) begin
            latch_q <= 1'b0;
        end
    end

    // guard and lock written only by status write
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            guard_q <= GUARD_RESET;
            lock_q <= LOCK_RESET;
        end else if (start_stat) begin
            guard_q <= rec_addr_q[ST_GUARD_LSB +: 3];
            lock_q <= rec_addr_q[ST_LOCK_BIT];
        end
    end

    // status image registered so the crossing sees clean bits
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stat_q <= 8'h00;
        end else begin
            stat_q <= 8'h00;
            stat_q[ST_LOCK_BIT] <= lock_q;
            stat_q[ST_GUARD_LSB +: 3] <= guard_q;
            stat_q[ST_LATCH_BIT] <= latch_q;
            stat_q[ST_BUSY_BIT] <= busy;
        end
    end

    // internal cycle machine: busy until timer and walk both finish
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= ST_IDLE;
            timer_q <= 32'h0000_0000;
            walk_q <= '0;
            left_q <= 20'h0_0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_prog) begin
                        state_q <= ST_PROG;
                        timer_q <= 32'(PROG_CYCLES - 1);
                        walk_q <= {rec_addr_q[18:8], 8'h00};
                        left_q <= PAGE_BYTES;
                    end else if (start_sector) begin
                        state_q <= ST_ERASE;
                        timer_q <= 32'(SECTOR_CYCLES - 1);
                        walk_q <= {rec_addr_q[18:16], 16'h0000};
                        left_q <= SECTOR_BYTES;
                    end else if (start_bulk) begin
                        state_q <= ST_ERASE;
                        timer_q <= 32'(BULK_CYCLES - 1);
                        walk_q <= '0;
                        left_q <= ARRAY_BYTES;
                    end else if (start_stat) begin
                        state_q <= ST_STATUS;
                        timer_q <= 32'(STATUS_CYCLES - 1);
                        left_q <= 20'h0_0000;
                    end
                end
                ST_PROG, ST_ERASE, ST_STATUS: begin
                    if (cycle_done) begin
                        state_q <= ST_IDLE;
                    end
                    if (timer_q != 32'h0000_0000) begin
                        timer_q <= timer_q - 32'h0000_0001;
                    end
                    if (left_q != 20'h0_0000) begin
                        walk_q <= walk_q + 19'h0_0001;
                        left_q <= left_q - 20'h0_0001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // array writes; page buffer is frozen while the walk reads it
    always_ff @(posedge clk_sys_in) begin
        if (left_q != 20'h0_0000) begin
            if (state_q == ST_PROG) begin
                if (page_mask_q[walk_q[7:0]]) begin
                    mem_q[walk_q] <= mem_q[walk_q] & page_buf_q[walk_q[7:0]];
                end
            end else if (state_q == ST_ERASE) begin
                mem_q[walk_q] <= 8'hFF;
            end
        end
    end
endmodule : sft_core
`default_nettype wire

// ==== pkg/sft_pkg.sv ====
// package: opcodes, status layout, geometry and timing for the serial flash target
//
// Operation
// - sample serial input on rising clock
// - change serial output on falling clock
// - deselected: output floats, logic idle
// - need select falling edge after power-up
// - pause low: float output, ignore inputs
// - protect pin plus lock bit: refuse status writes
// - modes 0 and 3, same edges
// - 524288 bytes in 2048 pages of 256
// - eight 64 KB sectors
// - program clears bits; sector/bulk erase only
// - program stays inside one page
// - erase fills sector or array with FFh
// - erase needs write latch set first
// - busy bit set during internal cycles
// - deselect never aborts internal cycles
// - sleep command holds until wake command
// - asleep: only wake command is obeyed
// - status bit mirrors write latch
// - guard bits retained, select protected region
// - guard code to protected sector map
// - write latch cleared on listed completions
// - msb first, opcode byte leads
// - write-type frames need whole bytes
package sft_pkg;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
    localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE_ID = 8'hAB;
    // status bit positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_GUARD_LSB = 2;
    localparam int ST_LOCK_BIT = 7;
    // reset value of guard and lock bits
    localparam logic [2:0] GUARD_RESET = 3'h0;
    localparam logic LOCK_RESET = 1'b0;
    // identity byte, value is arbitrary
    localparam logic [7:0] ID_DEFAULT = 8'h5A;
    localparam int ADDR_BITS = 19;
    localparam int ARRAY_WORDS = 524288;
    localparam logic [19:0] ARRAY_BYTES = 20'h8_0000;
    localparam logic [19:0] SECTOR_BYTES = 20'h1_0000;
    localparam logic [19:0] PAGE_BYTES = 20'h0_0100;
    // frame lengths in bytes
    localparam logic [15:0] ONE_BYTE = 16'h0001;
    localparam logic [15:0] STATUS_WR_BYTES = 16'h0002;
    localparam logic [15:0] HDR_BYTES = 16'h0004;
    localparam logic [15:0] WAKE_HDR_BYTES = 16'h0004;
    // timing at the system clock
    localparam int unsigned SYS_CLK_KHZ = 40000;
    localparam int unsigned PROG_TIME_US = 1500;
    localparam int unsigned SECTOR_TIME_MS = 800;
    localparam int unsigned BULK_TIME_MS = 5000;
    localparam int unsigned STATUS_TIME_US = 10;
    localparam int unsigned PROG_CYCLES = PROG_TIME_US * SYS_CLK_KHZ / 1000;
    localparam int unsigned SECTOR_CYCLES = SECTOR_TIME_MS * SYS_CLK_KHZ;
    localparam int unsigned BULK_CYCLES = BULK_TIME_MS * SYS_CLK_KHZ;
    localparam int unsigned STATUS_CYCLES = STATUS_TIME_US * SYS_CLK_KHZ / 1000;
    // internal cycle states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PROG = 4'b0010,
        ST_ERASE = 4'b0100,
        ST_STATUS = 4'b1000
    } sft_state_type;
    function automatic logic sft_guarded(input logic [18:0] a, input logic [2:0] g);
        case (g)
            3'h0: return 1'b0;
            3'h1: return a[18:16] == 3'h7;
            3'h2: return a[18:17] == 2'h3;
            3'h3: return a[18];
            default: return 1'b1;
        endcase
    endfunction : sft_guarded
endpackage : sft_pkg

// ==== sim/sft_core_asserts.sv ====
// checker: pin-level assertions for the serial flash target
`timescale 1ns/1ps
`default_nettype none
module sft_core_checker
    import sft_pkg::*;
(
    // clocks and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // link pins
    input wire logic link_sclk_in,
    input wire logic cs_n_in,
    input wire logic hold_n_in,
    input wire logic wp_n_in,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_oe_out
);
    logic [5:0] cnt_q; // bits this frame, saturating
    logic [7:0] sh_q; // last eight bits in
    logic hi_q; // output seen at last rising edge
    // shadow shifter, cleared by deselect like the real one
    always_ff @(posedge link_sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            cnt_q <= 6'h00;
            sh_q <= 8'h00;
        end else if (hold_n_in) begin
            sh_q <= {sh_q[6:0], serial_in};
            cnt_q <= (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
        end
    end
    // output value while the link clock is high
    always_ff @(posedge link_sclk_in) begin
        hi_q <= serial_out;
    end
    sequence status_op_seq;
        cnt_q == 6'h08 && sh_q == OP_STATUS_READ;
    endsequence
    sequence enable_op_seq;
        cnt_q == 6'h08 && sh_q == OP_WRITE_ENABLE;
    endsequence
    chk_desel_float: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        cs_n_in |-> !serial_oe_out) else $error("output driven while deselected");
    chk_hold_float: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        !cs_n_in && !hold_n_in |-> !serial_oe_out) else $error("output driven in pause");
    chk_reset_quiet: assert property (@(posedge clk_sys_in)
        !rstn_in |-> !serial_oe_out && !serial_out) else $error("output active in reset");
    chk_oe_select: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        $rose(serial_oe_out) |-> !cs_n_in && hold_n_in) else $error("enable without select");
    chk_oe_stands: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        $fell(serial_oe_out) |-> cs_n_in || !hold_n_in) else $error("enable dropped early");
    chk_out_falling: assert property (@(negedge link_sclk_in)
        disable iff (!rstn_in || cs_n_in || !hold_n_in)
        serial_oe_out |-> serial_out == hi_q) else $error("output moved while clock high");
    chk_status_answer: assert property (@(posedge link_sclk_in)
        disable iff (!rstn_in || cs_n_in || !hold_n_in)
        status_op_seq |-> serial_oe_out [*8]) else $error("status byte not driven");
    chk_enable_quiet: assert property (@(posedge link_sclk_in)
        disable iff (!rstn_in || cs_n_in) enable_op_seq |-> !serial_oe_out)
        else $error("output driven on write command");
    chk_oe_early: assert property (@(posedge link_sclk_in)
        disable iff (!rstn_in || cs_n_in) cnt_q < 6'h08 |-> !serial_oe_out)
        else $error("output driven inside opcode byte");
endmodule : sft_core_checker
bind sft_core sft_core_checker u_chk (.clk_sys_in, .rstn_in, .link_sclk_in, .cs_n_in,
    .hold_n_in, .wp_n_in, .serial_in, .serial_out, .serial_oe_out);
`default_nettype wire

// ==== sim/sft_host_model.sv ====
// host model: drives whole frames on the link in mode 0 or 3
`timescale 1ns/1ps
`default_nettype none
module sft_host_model (
    // launch clock
    input wire logic clk_sys_in,
    // link pins
    output logic sclk_out,
    output logic cs_n_out,
    output logic hold_n_out,
    output logic wp_n_out,
    output logic mosi_out,
    input wire logic miso_in
);
    logic mode3; // clock idles high when set
    initial begin
        mode3 = 1'b0;
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        hold_n_out = 1'b1;
        wp_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // one frame of n bits from the top of d; last byte read back
    task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk_sys_in);
        #2;
        // idle level chooses the mode
        // settle the new idle level while still deselected, so a mode change
        // never puts a stray rising edge inside the frame
        sclk_out = mode3;
        #24;
        // every frame drives select low; no falling edge when select is already held low
        cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            sclk_out = 1'b0;
            mosi_out = d[39-i];
            #24;
            sclk_out = 1'b1;
            rd = {rd[6:0], miso_in};
            #24;
        end
        sclk_out = mode3;
        #24;
        // deselect right after the last bit, whole byte or not
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out; // released line does not hold its value
        #200;
    endtask : xfer
endmodule : sft_host_model
`default_nettype wire

// ==== sim/test_serial_flash_spi_target_core.sv ====
// testbench: command rows, then pause, sleep and wake checks
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_spi_target_core;
    import sft_pkg::*;
    typedef struct {
        logic [39:0] d;
        int n;
        logic wp;
        logic busy;
        logic [7:0] st;
    } sft_row_type;
    logic clk_sys, rstn;
    wire logic sclk, cs_n, hold_n, wp_n, mosi, so, oe;
    wire logic miso;
    int err_count, tests_run;
    sft_row_type rows[16];
    logic [7:0] st;
    logic busy;
    assign miso = oe ? so : 1'bz;
    // short internal cycles keep the run brief
    sft_core #(.PROG_CYCLES(300), .SECTOR_CYCLES(100), .BULK_CYCLES(100),
        .STATUS_CYCLES(100)) uut (.clk_sys_in(clk_sys), .rstn_in(rstn),
        .link_sclk_in(sclk), .cs_n_in(cs_n), .hold_n_in(hold_n), .wp_n_in(wp_n),
        .serial_in(mosi), .serial_out(so), .serial_oe_out(oe));
    sft_host_model host (.clk_sys_in(clk_sys), .sclk_out(sclk), .cs_n_out(cs_n),
        .hold_n_out(hold_n), .wp_n_out(wp_n), .mosi_out(mosi), .miso_in(miso));
    function automatic sft_row_type mk(logic [39:0] d, int n, logic wp, logic b,
        logic [7:0] s);
        mk = '{d, n, wp, b, s};
    endfunction : mk
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // status read until idle, bounded
    task automatic poll(output logic [7:0] s, output logic b);
        b = 1'b0;
        for (int i = 0; i < 3000; i++) begin
            host.xfer({OP_STATUS_READ, 32'h0000_0000}, 16, s);
            if (s[0] !== 1'b1) break;
            b = 1'b1;
        end
    endtask : poll
    task automatic conclude;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // watchdog well past the sector erase walk
    initial begin
        #2_400_000;
        err_count++;
        conclude;
    end
    initial begin
        rstn = 1'b0;
        err_count = 0;
        tests_run = 0;
        // guard code 1 covers sector 7 only; sector 6 stays open
        // enable frame first, then four header bytes and data
        rows = '{mk({OP_WRITE_ENABLE, 32'h0}, 8, 1, 0, 8'h02),
            mk({OP_WRITE_DISABLE, 32'h0}, 8, 1, 0, 8'h00),
            mk({OP_WRITE_ENABLE, 32'h0}, 7, 1, 0, 8'h00),
            mk({OP_WRITE_ENABLE, 32'h0}, 8, 1, 0, 8'h02),
            mk({OP_PAGE_PROGRAM, 32'h0000_10AA}, 40, 1, 1, 8'h00),
            mk({OP_SECTOR_ERASE, 32'h0}, 32, 1, 0, 8'h00),
            mk({OP_WRITE_ENABLE, 32'h0}, 8, 1, 0, 8'h02),
            mk({OP_STATUS_WRITE, 32'h8400_0000}, 16, 1, 1, 8'h84),
            mk({OP_WRITE_ENABLE, 32'h0}, 8, 1, 0, 8'h86),
            mk({OP_BULK_ERASE, 32'h0}, 8, 1, 0, 8'h86),
            mk({OP_PAGE_PROGRAM, 32'h07FF_0011}, 40, 1, 0, 8'h86),
            mk({OP_SECTOR_ERASE, 32'h0600_0000}, 32, 1, 1, 8'h84),
            mk({OP_WRITE_ENABLE, 32'h0}, 8, 1, 0, 8'h86),
            mk({OP_STATUS_WRITE, 32'h0}, 16, 0, 0, 8'h86),
            mk({OP_STATUS_WRITE, 32'h0}, 16, 1, 1, 8'h00),
            mk({OP_WRITE_ENABLE, 32'h0}, 8, 1, 0, 8'h02)};
        #1 host.cs_n_out = 1'b0; // select held low across reset
        repeat (10) @(posedge clk_sys);
        #2 rstn = 1'b1;
        host.xfer({OP_WRITE_ENABLE, 32'h0}, 8, st);
        poll(st, busy);
        check(st, 8'h00);
        // rows alternate mode 0 and mode 3
        foreach (rows[k]) begin
            host.mode3 = k[0];
            host.wp_n_out = rows[k].wp;
            host.xfer(rows[k].d, rows[k].n, st);
            check({7'h00, oe}, 8'h00);
            poll(st, busy);
            check({7'h00, busy}, {7'h00, rows[k].busy});
            check(st, rows[k].st);
        end
        // pause held: disable frame must be ignored
        host.hold_n_out = 1'b0;
        host.xfer({OP_WRITE_DISABLE, 32'h0}, 8, st);
        host.hold_n_out = 1'b1;
        poll(st, busy);
        check(st, 8'h02);
        // asleep: disable ignored, wake returns the identity byte
        host.xfer({OP_DEEP_SLEEP, 32'h0}, 8, st);
        host.xfer({OP_WRITE_DISABLE, 32'h0}, 8, st);
        host.xfer({OP_WAKE_ID, 32'h0}, 40, st);
        check(st, ID_DEFAULT);
        poll(st, busy);
        check(st, 8'h02);
        conclude;
    end
endmodule : test_serial_flash_spi_target_core
`default_nettype wire
